/* rtl/gpfs_pkg.sv */
// constants and encodings for the gpio pin function select block
// ----------------------------------------------------------------
// ----------------------------------------------------------------
package gpfs_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int NUM_PINS = 8;

  localparam logic [7:0] OFS_PIN_FUNCTION_CONFIG = 8'h00;
  localparam logic [7:0] OFS_PIN_OUTPUT_DRIVE_ENABLE = 8'h04;

  localparam logic [15:0] RST_PIN_FUNCTION_CONFIG = 16'h0000;
  localparam logic [7:0] RST_OUTPUT_DRIVE_BITS = 8'h00;

  localparam int POS_PIN0 = 0;
  localparam int POS_PIN1 = 2;
  localparam int POS_PIN2 = 4;

  typedef enum logic [1:0] {
    GPFS_P0_IRQ0 = 2'b00,
    GPFS_P0_TRIG0 = 2'b01,
    GPFS_P0_SYNC0 = 2'b10,
    GPFS_P0_GPIO = 2'b11
  } gpfs_p0_mode_t;

  typedef enum logic [1:0] {
    GPFS_P1_GPIO = 2'b00,
    GPFS_P1_TRIG1 = 2'b01,
    GPFS_P1_SYNC1 = 2'b10,
    GPFS_P1_SLEEP = 2'b11
  } gpfs_p1_mode_t;

  typedef enum logic [1:0] {
    GPFS_P2_POR = 2'b00,
    GPFS_P2_TRIG2 = 2'b01,
    GPFS_P2_SYNC2 = 2'b10,
    GPFS_P2_EXTERNAL_CLOCK_INPUT = 2'b11
  } gpfs_p2_mode_t;

endpackage : gpfs_pkg

/* rtl/gpfs_sync2.sv */
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module gpfs_sync2 #(
  parameter int W = 3
) (
  input wire logic clk, // core clock
  input wire logic arst_n, // async reset, active low
  input wire logic [W-1:0] d, // asynchronous input
  output logic [W-1:0] q // synchronised output
);
  logic [W-1:0] meta_ff;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_ff <= '0;
      q <= '0;
    end else begin
      meta_ff <= d;
      q <= meta_ff;
    end
  end
endmodule : gpfs_sync2
`default_nettype wire

/* rtl/gpfs_pin_route.sv */
// combinational role decode for pins 0..2
`timescale 1ns/1ps
`default_nettype none
module gpfs_pin_route (
  input wire logic [1:0] pin0_function_field, // pin0 role code
  input wire logic [1:0] pin1_function_field, // pin1 role code
  input wire logic [1:0] pin2_function_field, // pin2 role code
  input wire logic irq0, // interrupt 0 level
  input wire logic sleep_flag, // high while hibernating
  input wire logic por_status, // power-on-reset status
  input wire logic [2:0] sync_out, // sync outputs for ext devices 0..2
  input wire logic [2:0] gpio_out, // gpio data for pins 0 and 1; pin2 has no gpio role
  output logic [2:0] func_out, // level to drive on pins 0..2
  output logic [2:0] trig_sel, // pin is a sequence trigger input
  output logic external_clock_input_sel // pin2 acts as external clock input
);
  always_comb begin
    func_out = 3'h0;
    trig_sel = 3'h0;
    external_clock_input_sel = 1'b0;
    unique case (gpfs_pkg::gpfs_p0_mode_t'(pin0_function_field))
      gpfs_pkg::GPFS_P0_IRQ0: func_out[0] = irq0;
      gpfs_pkg::GPFS_P0_TRIG0: trig_sel[0] = 1'b1;
      gpfs_pkg::GPFS_P0_SYNC0: func_out[0] = sync_out[0];
      gpfs_pkg::GPFS_P0_GPIO: func_out[0] = gpio_out[0];
    endcase
    unique case (gpfs_pkg::gpfs_p1_mode_t'(pin1_function_field))
      gpfs_pkg::GPFS_P1_GPIO: func_out[1] = gpio_out[1];
      gpfs_pkg::GPFS_P1_TRIG1: trig_sel[1] = 1'b1;
      gpfs_pkg::GPFS_P1_SYNC1: func_out[1] = sync_out[1];
      gpfs_pkg::GPFS_P1_SLEEP: func_out[1] = sleep_flag;
    endcase
    unique case (gpfs_pkg::gpfs_p2_mode_t'(pin2_function_field))
      gpfs_pkg::GPFS_P2_POR: func_out[2] = por_status;
      gpfs_pkg::GPFS_P2_TRIG2: trig_sel[2] = 1'b1;
      gpfs_pkg::GPFS_P2_SYNC2: func_out[2] = sync_out[2];
      gpfs_pkg::GPFS_P2_EXTERNAL_CLOCK_INPUT: external_clock_input_sel = 1'b1;
    endcase
  end
endmodule : gpfs_pin_route
`default_nettype wire

/* rtl/gpfs_top.sv */
// pin function select and output drive enable, top level
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module gpfs_top (
  input wire logic clk, // core clock, 125 MHz
  input wire logic arst_n, // async reset, active low
  input wire logic [7:0] reg_addr, // register byte address
  input wire logic [15:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [15:0] reg_rdata, // read data, cycle after strobe
  input wire logic irq0, // interrupt 0 level from core
  input wire logic sleep_flag, // hibernate indication from core
  input wire logic por_status, // power-on-reset status from core
  input wire logic [2:0] sync_out, // sync outputs for ext devices 0..2
  input wire logic [7:0] gpio_out, // gpio data out for pins 0, 1 and 3..7; pin2 has no gpio role
  input wire logic [7:0] pin_in, // pin levels, asynchronous
  output logic [7:0] pin_out, // pin output level
  output logic [7:0] pin_oe, // pin output enable, high drives
  output logic [2:0] seq_trigger, // sequence 0..2 trigger levels
  output logic ext_clock_in, // external clock level from pin2
  output logic [7:0] pin_in_sync // synchronised pin levels
);
  logic [15:0] pin_function_config_ff;
  logic [7:0] output_drive_bits_ff;
  logic [15:0] nxt_rdata;
  logic [7:0] pin_sync;
  logic [2:0] func_out;
  logic [2:0] trig_sel;
  logic external_clock_input_sel;
  logic [2:0] seq_trigger_ff;
  logic ext_clock_in_ff;
  logic [2:0] pin_out_role_ff;
  logic [4:0] pin_out_gpio_ff;
  logic cfg_wr_en;
  logic oe_wr_en;
  logic [1:0] pin0_function_field;
  logic [1:0] pin1_function_field;
  logic [1:0] pin2_function_field;

  // ----------------------------------------
  // address decode, shared by write and read paths
  // ----------------------------------------
  function automatic logic hit_cfg(input logic [7:0] addr);
    return addr == gpfs_pkg::OFS_PIN_FUNCTION_CONFIG;
  endfunction : hit_cfg

  function automatic logic hit_oe(input logic [7:0] addr);
    return addr == gpfs_pkg::OFS_PIN_OUTPUT_DRIVE_ENABLE;
  endfunction : hit_oe

  // unmapped offsets match neither decode, so their writes are dropped
  assign cfg_wr_en = reg_wr && hit_cfg(reg_addr);
  assign oe_wr_en = reg_wr && hit_oe(reg_addr);

  // ----------------------------------------
  // register writes
  // ----------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_function_config_ff <= gpfs_pkg::RST_PIN_FUNCTION_CONFIG;
    end else if (cfg_wr_en) begin
      pin_function_config_ff <= reg_wdata;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      output_drive_bits_ff <= gpfs_pkg::RST_OUTPUT_DRIVE_BITS;
    end else if (oe_wr_en) begin
      output_drive_bits_ff <= reg_wdata[7:0];
    end
  end

  // ----------------------------------------
  // register reads
  // ----------------------------------------
  always_comb begin
    nxt_rdata = 16'h0000;
    if (hit_cfg(reg_addr)) begin
      nxt_rdata = pin_function_config_ff;
    end else if (hit_oe(reg_addr)) begin
      nxt_rdata = {8'h00, output_drive_bits_ff};
    end
  end

  // read data held only in the cycle after the strobe
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      reg_rdata <= nxt_rdata;
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // ----------------------------------------
  // pin input synchronisation and routing
  // ----------------------------------------
  gpfs_sync2 #(
    .W(gpfs_pkg::NUM_PINS)
  ) u_sync (
    .clk(clk),
    .arst_n(arst_n),
    .d(pin_in),
    .q(pin_sync)
  );

  assign pin0_function_field = pin_function_config_ff[gpfs_pkg::POS_PIN0 +: 2];
  assign pin1_function_field = pin_function_config_ff[gpfs_pkg::POS_PIN1 +: 2];
  assign pin2_function_field = pin_function_config_ff[gpfs_pkg::POS_PIN2 +: 2];

  gpfs_pin_route u_route (
    .pin0_function_field(pin0_function_field),
    .pin1_function_field(pin1_function_field),
    .pin2_function_field(pin2_function_field),
    .irq0(irq0),
    .sleep_flag(sleep_flag),
    .por_status(por_status),
    .sync_out(sync_out),
    .gpio_out(gpio_out[2:0]),
    .func_out(func_out),
    .trig_sel(trig_sel),
    .external_clock_input_sel(external_clock_input_sel)
  );

  // input roles read only synchronised levels; unused roles read low
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      seq_trigger_ff <= 3'h0;
    end else begin
      seq_trigger_ff <= trig_sel & pin_sync[2:0];
    end
  end

  // pin2 level passes only in the clock role, so trigger toggles on that
  // pin never reach the clock consumer
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ext_clock_in_ff <= 1'b0;
    end else begin
      ext_clock_in_ff <= external_clock_input_sel & pin_sync[2];
    end
  end

  // ----------------------------------------
  // pin drive levels
  // ----------------------------------------
  // input roles drive low; the enable alone decides if that reaches the pad
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_out_role_ff <= 3'h0;
    end else begin
      pin_out_role_ff <= func_out;
    end
  end

  // pins 3..7 have no role field in this block and carry gpio data only
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_out_gpio_ff <= 5'h00;
    end else begin
      pin_out_gpio_ff <= gpio_out[7:3];
    end
  end

  assign pin_oe = output_drive_bits_ff;
  assign pin_out = {pin_out_gpio_ff, pin_out_role_ff};
  assign seq_trigger = seq_trigger_ff;
  assign ext_clock_in = ext_clock_in_ff;
  assign pin_in_sync = pin_sync;

endmodule : gpfs_top
`default_nettype wire

/* tb/gpfs_assertions.sv */
// checker for register and pin role behaviour
`timescale 1ns/1ps
`default_nettype none
module gpfs_assertions (
  input wire logic clk, // clk
  input wire logic arst_n, // reset
  input wire logic [7:0] reg_addr, // addr
  input wire logic [15:0] reg_wdata, // wdata
  input wire logic reg_wr, // write
  input wire logic reg_rd, // read
  input wire logic [15:0] reg_rdata, // rdata
  input wire logic irq0, // irq
  input wire logic sleep_flag, // sleep
  input wire logic por_status, // por
  input wire logic [2:0] sync_out, // sync
  input wire logic [7:0] pin_out, // drive
  input wire logic [7:0] pin_oe, // enable
  input wire logic [2:0] seq_trigger, // triggers
  input wire logic [7:0] pin_in_sync // synced
);
  // ----
  // shadow of role fields
  // ----
  logic [5:0] cfg_ff;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) cfg_ff <= 6'h00;
    else if (reg_wr && reg_addr == 8'h00) cfg_ff <= reg_wdata[5:0];
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence s_oe_wr; reg_wr && reg_addr == 8'h04; endsequence
  sequence s_oe_rd; reg_rd && reg_addr == 8'h04; endsequence
  a_oe_write: assert property (s_oe_wr |=> pin_oe == $past(reg_wdata[7:0]))
    else $error("oe write");
  a_oe_hold: assert property (!(reg_wr && reg_addr == 8'h04) |=> $stable(pin_oe))
    else $error("oe hold");
  a_oe_read: assert property (s_oe_rd |=> reg_rdata == {8'h00, $past(pin_oe)})
    else $error("oe read");
  a_pin0_irq: assert property (cfg_ff[1:0] == 2'h0 |=> pin_out[0] == $past(irq0))
    else $error("pin0 irq");
  a_pin0_trig: assert property (cfg_ff[1:0] == 2'h1 |=> seq_trigger[0] == $past(pin_in_sync[0]))
    else $error("pin0 trig");
  a_pin1_sleep: assert property (cfg_ff[3:2] == 2'h3 |=> pin_out[1] == $past(sleep_flag))
    else $error("pin1 sleep");
  a_pin2_por: assert property (cfg_ff[5:4] == 2'h0 |=> pin_out[2] == $past(por_status))
    else $error("pin2 por");
  a_pin2_sync: assert property (cfg_ff[5:4] == 2'h2 |=> pin_out[2] == $past(sync_out[2]))
    else $error("pin2 sync");
endmodule : gpfs_assertions
`default_nettype wire

/* tb/gpfs_partner.sv */
// pin-side model of host and external devices
`timescale 1ns/1ps
`default_nettype none
module gpfs_partner (
  input wire logic clk, // clk
  input wire logic arst_n, // reset
  input wire logic [7:0] pin_out, // device drive
  input wire logic [7:0] pin_oe, // device enable
  input wire logic [7:0] ext_lvl, // far drive
  output logic [7:0] pin_in, // wire level
  output logic host_woke // host saw sleep flag
);
  // ----
  // wire level, device wins where enabled
  // ----
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) host_woke <= 1'b0;
    else host_woke <= pin_oe[1] & pin_out[1];
  end
endmodule : gpfs_partner
`default_nettype wire

/* tb/gpfs_top_bench.sv */
// self-checking bench for the pin function select block
`timescale 1ns/1ps
`default_nettype none
module gpfs_top_bench;
  logic clk, arst_n, reg_wr, reg_rd, irq0, sleep_flag, por_status, ext_clock_in, host_woke;
  logic [7:0] reg_addr, gpio_out, pin_in, pin_out, pin_oe, pin_in_sync, ext_lvl;
  logic [15:0] reg_wdata, reg_rdata;
  logic [2:0] sync_out, seq_trigger, e;
  int fails, checks;
  gpfs_top dut_u (
    .clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq0(irq0), .sleep_flag(sleep_flag),
    .por_status(por_status), .sync_out(sync_out), .gpio_out(gpio_out), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .seq_trigger(seq_trigger),
    .ext_clock_in(ext_clock_in), .pin_in_sync(pin_in_sync)
  );
  gpfs_partner far_u (
    .clk(clk), .arst_n(arst_n), .pin_out(pin_out), .pin_oe(pin_oe), .ext_lvl(ext_lvl),
    .pin_in(pin_in), .host_woke(host_woke)
  );
  // ----
  // clock, bus and compare tasks
  // ----
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s exp %h got %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [15:0] exp, input string what);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk(what, reg_rdata, exp);
    @(posedge clk);
  endtask : rd
  task automatic t_regs();
    rd(8'h00, 16'h0000, "cfg reset");
    rd(8'h04, 16'h0000, "oe reset");
    wr(8'h04, 16'hA5FF);
    rd(8'h04, 16'h00FF, "oe upper");
    chk("oe pins", pin_oe, 16'h00FF);
    wr(8'h08, 16'h0000);
    rd(8'h08, 16'h0000, "unmapped");
    rd(8'h04, 16'h00FF, "oe kept");
    arst_n <= 1'b0;
    @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    chk("oe off", pin_oe, 16'h0000);
    rd(8'h04, 16'h0000, "oe rerst");
    $display("t_regs done");
  endtask : t_regs
  task automatic t_roles();
    wr(8'h04, 16'h00FA);
    @(posedge clk);
    chk("oe roles", pin_oe, 16'h00FA);
    for (int v = 0; v < 2; v++) begin
      for (int c = 0; c < 4; c++) begin
        {irq0, sleep_flag, por_status, sync_out, gpio_out, ext_lvl} <= {6'h2A, 16'hA505} ^ {22{v[0]}};
        wr(8'h00, {10'h000, c[1:0], c[1:0], c[1:0]});
        repeat (5) @(posedge clk);
        @(negedge clk);
        e[0] = c == 0 ? irq0 : c == 2 ? sync_out[0] : c == 3 ? gpio_out[0] : 1'b0;
        e[1] = c == 0 ? gpio_out[1] : c == 2 ? sync_out[1] : c == 3 ? sleep_flag : 1'b0;
        e[2] = c == 0 ? por_status : c == 2 ? sync_out[2] : 1'b0;
        chk("pins 0..2", pin_out[2:0], e);
        chk("gpio pins", pin_out[7:3], gpio_out[7:3]);
        chk("triggers", seq_trigger, c == 1 ? {ext_lvl[2], 1'b0, ext_lvl[0]} : 3'h0);
        chk("ext clock", ext_clock_in, c == 3 ? ext_lvl[2] : 1'b0);
        chk("synced pins", pin_in_sync, {gpio_out[7:3], ext_lvl[2], e[1], ext_lvl[0]});
        if (c == 3) chk("host flag", host_woke, sleep_flag);
        @(posedge clk);
        rd(8'h00, {10'h000, c[1:0], c[1:0], c[1:0]}, "cfg read");
      end
    end
    chk("host woke", host_woke, 1'b1);
    $display("t_roles done");
  endtask : t_roles
  task automatic results();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : results
  initial begin
    {arst_n, reg_wr, reg_rd, irq0, sleep_flag, por_status, sync_out} <= '0;
    {reg_addr, gpio_out, ext_lvl, reg_wdata} <= '0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_roles();
    results();
  end
  initial begin
    repeat (500) @(posedge clk);
    fails++;
    results();
  end
endmodule : gpfs_top_bench
bind gpfs_top gpfs_assertions chk_u (
  .clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq0(irq0), .sleep_flag(sleep_flag),
  .por_status(por_status), .sync_out(sync_out), .pin_out(pin_out), .pin_oe(pin_oe),
  .seq_trigger(seq_trigger), .pin_in_sync(pin_in_sync)
);
`default_nettype wire
